/* dac_trim_and_output_control_test.sv */
`timescale 1ns/100ps
`default_nettype none
module dac_trim_and_output_control_test import dtc_pkg::*; ;
    logic                    clk, rst, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
    logic                    rvalid, rready, supply_stable, sup_n, det_n, amp, clamp, brownout, lgnd;
    logic                    p0_i, p0_o, p0_oe, p1_i, p1_o, p1_oe;
    logic [7:0]              awaddr, araddr;
    logic [31:0]             wdata, rdata, rd;
    logic [3:0]              wstrb;
    logic [1:0]              bresp, rresp, resp, ext_lvl;
    logic [NCH-1:0][DW-1:0]  dac;
    logic [NCH-1:0][OFW-1:0] ofs;
    logic [NCH-1:0][FGW-1:0] fine;
    logic [NCH-1:0][RGW-1:0] rng;
    int                      n_errors = 0;
    int                      cmp_count = 0;
    localparam logic [7:0]   OFS_TAB [4] = '{8'h7f, 8'h80, 8'hf0, 8'h01};
    localparam logic [5:0]   FINE_TAB [4] = '{6'h1f, 6'h20, 6'h08, 6'h3f};

    dtc_trim_ctrl dut (
        .clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .supply_stable(supply_stable),
        .supervisor_reset_input_n(sup_n), .supply_detector_output_n(det_n),
        .amplifier_connect_gate(amp), .output_clamp_gate(clamp), .gp_port_pin_zero_i(p0_i),
        .gp_port_pin_zero_o(p0_o), .gp_port_pin_zero_oe(p0_oe), .gp_port_pin_one_i(p1_i),
        .gp_port_pin_one_o(p1_o), .gp_port_pin_one_oe(p1_oe), .dac_code(dac), .offset_trim_code(ofs),
        .fine_trim_code(fine), .range_code(rng), .local_ground_adjust_en(lgnd)
    );
    dtc_pin_model board (
        .brownout(brownout), .ext_lvl(ext_lvl), .pin0_o(p0_o), .pin0_oe(p0_oe), .pin1_o(p1_o),
        .pin1_oe(p1_oe), .pin0_lvl(p0_i), .pin1_lvl(p1_i), .supervisor_n(sup_n)
    );

    always #2.5 clk = ~clk;

    // ****************************************
    // bus tasks and checks
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
        // idle edge keeps the next call off this release
        @(posedge clk);
    endtask : axi_write

    task automatic axi_read(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
        @(posedge clk);
    endtask : axi_read

    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_of_test

    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        end_of_test();
    end

    // ****************************************
    // test sequence
    // ****************************************
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        awvalid = 1'b0;
        wvalid = 1'b0;
        bready = 1'b0;
        arvalid = 1'b0;
        rready = 1'b0;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        wstrb = 4'hf;
        supply_stable = 1'b0;
        brownout = 1'b0;
        ext_lvl = 2'b00;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        check({clamp, amp, p0_oe, p1_oe, det_n, lgnd}, 6'b100000);
        for (int i = 0; i < 4; i++) check({dac[i], ofs[i], fine[i]}, {16'h8000, 14'h0});
        check(rng, 8'h00);
        axi_write(OFS_DATA, 32'h0);
        check({dac[0], clamp}, {16'h8000, 1'b1});
        supply_stable <= 1'b1;
        repeat (6) @(posedge clk);
        check({clamp, amp, det_n}, 3'b101);
        axi_read(OFS_STATUS);
        check(rd, 32'h7);
        axi_write(OFS_DATA + 8'h04, 32'h8000);
        check({dac[1], clamp, amp, resp}, {16'h0, 2'b01, RESP_OKAY});
        brownout <= 1'b1;
        repeat (5) @(posedge clk);
        check({clamp, amp}, 2'b10);
        axi_read(OFS_STATUS);
        check(rd, 32'h3);
        brownout <= 1'b0;
        repeat (6) @(posedge clk);
        check({clamp, amp}, 2'b10);
        axi_write(OFS_DATA + 8'h08, 32'h7fff);
        check({dac[2], clamp, amp}, {16'hffff, 2'b01});
        supply_stable <= 1'b0;
        repeat (5) @(posedge clk);
        check({clamp, amp, det_n}, 3'b100);
        supply_stable <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            axi_write(OFS_OFFSET + 8'(4 * i), {24'hffffff, OFS_TAB[i]});
            axi_write(OFS_FINE + 8'(4 * i), {26'h3ffffff, FINE_TAB[i]});
            check({ofs[i], fine[i]}, {OFS_TAB[i], FINE_TAB[i]});
            axi_read(OFS_OFFSET + 8'(4 * i));
            check(rd, {24'h0, OFS_TAB[i]});
            axi_read(OFS_FINE + 8'(4 * i));
            check(rd, {26'h0, FINE_TAB[i]});
        end
        check({ofs[0], fine[0]}, {8'h7f, 6'h1f});
        axi_write(OFS_RANGE, 32'ha4);
        check(rng, 8'ha4);
        axi_write(OFS_RANGE, 32'h17);
        check(rng, 8'h14);
        axi_read(OFS_RANGE);
        check(rd, 32'h14);
        axi_write(OFS_FUNC, 32'h16);
        repeat (4) @(posedge clk);
        check({p0_oe, p0_o, p1_oe}, 3'b110);
        axi_read(OFS_FUNC);
        check(rd, 32'h06);
        ext_lvl <= 2'b10;
        repeat (5) @(posedge clk);
        axi_read(OFS_FUNC);
        check(rd, 32'h16);
        ext_lvl <= 2'b11;
        axi_write(OFS_FUNC, 32'h08);
        repeat (5) @(posedge clk);
        check({p0_oe, p1_oe, p1_o}, 3'b010);
        axi_read(OFS_FUNC);
        check(rd, 32'h0c);
        axi_write(OFS_FUNC, 32'h21);
        check(lgnd, 1'b1);
        axi_write(OFS_DATA + 8'h0c, 32'h1234);
        check(dac[3], 16'h1234);
        axi_write(OFS_FUNC, 32'h20);
        check(lgnd, 1'b0);
        axi_read(8'h3c);
        check(resp, RESP_SLVERR);
        check(rd, 32'h0);
        axi_write(8'h40, 32'hff);
        check(resp, RESP_SLVERR);
        end_of_test();
    end
endmodule : dac_trim_and_output_control_test
`default_nettype wire

/* dtc_pin_model.sv */
`timescale 1ns/100ps
`default_nettype none
module dtc_pin_model (
    input  wire logic       brownout,     // supply bad seen by supervisor
    input  wire logic [1:0] ext_lvl,      // outside switch levels
    input  wire logic       pin0_o,       // device value pin 0
    input  wire logic       pin0_oe,      // device enable pin 0
    input  wire logic       pin1_o,       // device value pin 1
    input  wire logic       pin1_oe,      // device enable pin 1
    output var  logic       pin0_lvl,     // wire level pin 0
    output var  logic       pin1_lvl,     // wire level pin 1
    output var  logic       supervisor_n  // supervisor output
);
    // ****************************************
    // supervisor and port wires
    // ****************************************
    always_comb begin
        supervisor_n = !brownout;
        pin0_lvl = pin0_oe ? pin0_o : ext_lvl[0];
        pin1_lvl = pin1_oe ? pin1_o : ext_lvl[1];
    end
endmodule : dtc_pin_model
`default_nettype wire

/* dtc_pkg.sv */
`default_nettype none
// ****************************************
// dtc constants
// ****************************************
package dtc_pkg;
    localparam int unsigned NCH = 4;
    localparam int unsigned DW  = 16;
    localparam int unsigned OFW = 8;
    localparam int unsigned FGW = 6;
    localparam int unsigned RGW = 2;
    localparam int unsigned AW  = 8;

    // byte offsets of the register map
    localparam logic [7:0] OFS_DATA   = 8'h00;
    localparam logic [7:0] OFS_OFFSET = 8'h10;
    localparam logic [7:0] OFS_FINE   = 8'h20;
    localparam logic [7:0] OFS_RANGE  = 8'h30;
    localparam logic [7:0] OFS_FUNC   = 8'h34;
    localparam logic [7:0] OFS_STATUS = 8'h38;

    // function register fields
    localparam int unsigned F_LGND  = 0;
    localparam int unsigned F_D0DIR = 1;
    localparam int unsigned F_D0VAL = 2;
    localparam int unsigned F_D1DIR = 3;
    localparam int unsigned F_D1VAL = 4;
    localparam int unsigned F_BIN   = 5;
    localparam int unsigned FNW     = 6;

    // status register fields
    localparam int unsigned S_CLAMP = 0;
    localparam int unsigned S_SUPOK = 1;
    localparam int unsigned S_SUPERVISOR_RESET_INPUT = 2;

    localparam logic [DW-1:0]  DATA_RST   = 16'h0000;
    localparam logic [OFW-1:0] OFFSET_RST = 8'h00;
    localparam logic [FGW-1:0] FINE_RST   = 6'h00;
    localparam logic [RGW-1:0] RANGE_STD  = 2'h0;
    localparam logic [RGW-1:0] RANGE_MID  = 2'h1;
    localparam logic [RGW-1:0] RANGE_WIDE = 2'h2;
    localparam logic [RGW-1:0] RANGE_RSVD = 2'h3;
    localparam logic [FNW-1:0] FUNC_RST   = 6'h00;
    localparam logic [DW-1:0]  MSB_FLIP   = 16'h8000;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        CL_CLAMPED = 2'h0,
        CL_ARMED   = 2'h1,
        CL_RUN     = 2'h3
    } dtc_clamp_e;
endpackage : dtc_pkg
`default_nettype wire

/* dtc_trim_ctrl.sv */
// How it works
// - offset trim per channel is an 8-bit two's complement code, eighth-LSB steps.
// - fine gain trim per channel is a 6-bit two's complement code.
// - two's complement coding maps 0x0000 to zero, 0x8000 to negative full scale.
// - while supplies change, outputs clamp to zero and the amplifier disconnects.
// - clamp releases on the first data word written after supplies are stable.
// - supervisor reset input low forces clamp and amplifier disconnect.
// - internal supply detector state is driven on its own output pin.
// - each channel selects one of three coarse output ranges.
// - two general-purpose pins, each independently input or output.
// - output pins drive written values; input pin levels read back.
// - local ground compensation acts only when enabled in function register.
// - range code 00 default, 01 middle, 10 widest; 11 is ignored.
// - both general-purpose pins are inputs after reset.
`timescale 1ns/100ps
`default_nettype none
module dtc_trim_ctrl
    import dtc_pkg::*;
(
    input  wire logic                      clk,                      // 200 MHz clock
    input  wire logic                      rst,                      // sync reset, high
    input  wire logic [AW-1:0]             s_axi_awaddr,             // write address
    input  wire logic                      s_axi_awvalid,            // write address valid
    output var  logic                      s_axi_awready,            // write address ready
    input  wire logic [31:0]               s_axi_wdata,              // write data
    input  wire logic [3:0]                s_axi_wstrb,              // byte enables
    input  wire logic                      s_axi_wvalid,             // write data valid
    output var  logic                      s_axi_wready,             // write data ready
    output var  logic [1:0]                s_axi_bresp,              // write response
    output var  logic                      s_axi_bvalid,             // write response valid
    input  wire logic                      s_axi_bready,             // write response ready
    input  wire logic [AW-1:0]             s_axi_araddr,             // read address
    input  wire logic                      s_axi_arvalid,            // read address valid
    output var  logic                      s_axi_arready,            // read address ready
    output var  logic [31:0]               s_axi_rdata,              // read data
    output var  logic [1:0]                s_axi_rresp,              // read response
    output var  logic                      s_axi_rvalid,             // read data valid
    input  wire logic                      s_axi_rready,             // read data ready
    input  wire logic                      supply_stable,            // raw supply detector
    input  wire logic                      supervisor_reset_input_n, // external clamp force
    output var  logic                      supply_detector_output_n, // low while supply bad
    output var  logic                      amplifier_connect_gate,   // high: amp connected
    output var  logic                      output_clamp_gate,        // high: output clamped
    input  wire logic                      gp_port_pin_zero_i,       // pin 0 level
    output var  logic                      gp_port_pin_zero_o,       // pin 0 drive value
    output var  logic                      gp_port_pin_zero_oe,      // pin 0 drive enable
    input  wire logic                      gp_port_pin_one_i,        // pin 1 level
    output var  logic                      gp_port_pin_one_o,        // pin 1 drive value
    output var  logic                      gp_port_pin_one_oe,       // pin 1 drive enable
    output var  logic [NCH-1:0][DW-1:0]    dac_code,                 // binary core codes
    output var  logic [NCH-1:0][OFW-1:0]   offset_trim_code,         // per-channel offset
    output var  logic [NCH-1:0][FGW-1:0]   fine_trim_code,           // per-channel fine gain
    output var  logic [NCH-1:0][RGW-1:0]   range_code,               // per-channel range
    output var  logic                      local_ground_adjust_en    // ground compensation
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic                    aw_have;
        logic [AW-1:0]           aw_addr;
        logic                    w_have;
        logic [31:0]             w_data;
        logic [3:0]              w_strb;
        logic                    awready;
        logic                    wready;
        logic                    bvalid;
        logic [1:0]              bresp;
        logic                    arready;
        logic                    rvalid;
        logic [31:0]             rdata;
        logic [1:0]              rresp;
        logic                    sup_s1;
        logic                    sup_s2;
        logic                    rin_s1;
        logic                    rin_s2;
        logic [1:0]              gp_s1;
        logic [1:0]              gp_s2;
        logic [NCH-1:0][DW-1:0]  data;
        logic [NCH-1:0][DW-1:0]  code;
        logic [NCH-1:0][OFW-1:0] ofs;
        logic [NCH-1:0][FGW-1:0] fine;
        logic [NCH-1:0][RGW-1:0] rng;
        logic [FNW-1:0]          func;
        dtc_clamp_e              clamp;
        logic                    amp_gate;
        logic                    clamp_gate;
        logic                    det_n;
    } dtc_state_s;

    dtc_state_s st_reg;
    dtc_state_s st_next;

    // ****************************************
    // helpers
    // ****************************************
    // true when the address is one of four channel words above base
    function automatic logic dtc_in_bank(input logic [AW-1:0] a, input logic [AW-1:0] base);
        return (a[AW-1:4] == base[AW-1:4]) && (a[1:0] == 2'h0);
    endfunction : dtc_in_bank

    // byte-lane merge of a write into an old word
    function automatic logic [31:0] dtc_merge(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction : dtc_merge

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        logic [31:0]  wv;
        logic [31:0]  rv;
        logic [1:0]   ch;
        logic         hit;
        logic         data_wr;
        logic         sup_ok;
        logic         rin_ok;
        logic [FNW-1:0] fv;
        wv      = 32'h0;
        rv      = 32'h0;
        ch      = 2'h0;
        hit     = 1'b0;
        data_wr = 1'b0;
        fv      = FUNC_RST;
        sup_ok  = st_reg.sup_s2;
        rin_ok  = st_reg.rin_s2;
        st_next = st_reg;

        // two-stage capture of every outside level
        st_next.sup_s1 = supply_stable;
        st_next.sup_s2 = st_reg.sup_s1;
        st_next.rin_s1 = supervisor_reset_input_n;
        st_next.rin_s2 = st_reg.rin_s1;
        st_next.gp_s1  = {gp_port_pin_one_i, gp_port_pin_zero_i};
        st_next.gp_s2  = st_reg.gp_s1;

        // ****************************************
        // write channel
        // ****************************************
        if (st_reg.awready && s_axi_awvalid) begin
            st_next.aw_have = 1'b1;
            st_next.aw_addr = s_axi_awaddr;
        end
        if (st_reg.wready && s_axi_wvalid) begin
            st_next.w_have = 1'b1;
            st_next.w_data = s_axi_wdata;
            st_next.w_strb = s_axi_wstrb;
        end
        if (st_reg.bvalid && s_axi_bready) begin
            st_next.bvalid = 1'b0;
        end
        if (st_next.aw_have && st_next.w_have && !st_next.bvalid) begin
            ch  = st_next.aw_addr[3:2];
            hit = 1'b1;
            if (dtc_in_bank(st_next.aw_addr, OFS_DATA)) begin
                wv = dtc_merge({16'h0, st_reg.data[ch]}, st_next.w_data, st_next.w_strb);
                st_next.data[ch] = wv[DW-1:0];
                data_wr = 1'b1;
            end else if (dtc_in_bank(st_next.aw_addr, OFS_OFFSET)) begin
                wv = dtc_merge({24'h0, st_reg.ofs[ch]}, st_next.w_data, st_next.w_strb);
                st_next.ofs[ch] = wv[OFW-1:0];
            end else if (dtc_in_bank(st_next.aw_addr, OFS_FINE)) begin
                wv = dtc_merge({26'h0, st_reg.fine[ch]}, st_next.w_data, st_next.w_strb);
                st_next.fine[ch] = wv[FGW-1:0];
            end else if (st_next.aw_addr == OFS_RANGE) begin
                wv = dtc_merge({24'h0, st_reg.rng}, st_next.w_data, st_next.w_strb);
                // reserved range code keeps old value
                for (int c = 0; c < NCH; c++) begin
                    if (wv[c*RGW +: RGW] != RANGE_RSVD) begin
                        st_next.rng[c] = wv[c*RGW +: RGW];
                    end
                end
            end else if (st_next.aw_addr == OFS_FUNC) begin
                wv = dtc_merge({26'h0, st_reg.func}, st_next.w_data, st_next.w_strb);
                st_next.func = wv[FNW-1:0];
            end else begin
                hit = 1'b0;
            end
            st_next.bresp   = hit ? RESP_OKAY : RESP_SLVERR;
            st_next.bvalid  = 1'b1;
            st_next.aw_have = 1'b0;
            st_next.w_have  = 1'b0;
        end
        st_next.awready = !st_next.aw_have && !st_next.bvalid;
        st_next.wready  = !st_next.w_have && !st_next.bvalid;

        // ****************************************
        // read channel
        // ****************************************
        if (st_reg.rvalid && s_axi_rready) begin
            st_next.rvalid = 1'b0;
        end
        if (st_reg.arready && s_axi_arvalid) begin
            ch  = s_axi_araddr[3:2];
            hit = 1'b1;
            // input pins read their live level
            fv = st_reg.func;
            if (!st_reg.func[F_D0DIR]) begin
                fv[F_D0VAL] = st_reg.gp_s2[0];
            end
            if (!st_reg.func[F_D1DIR]) begin
                fv[F_D1VAL] = st_reg.gp_s2[1];
            end
            if (dtc_in_bank(s_axi_araddr, OFS_DATA)) begin
                rv = {16'h0, st_reg.data[ch]};
            end else if (dtc_in_bank(s_axi_araddr, OFS_OFFSET)) begin
                rv = {24'h0, st_reg.ofs[ch]};
            end else if (dtc_in_bank(s_axi_araddr, OFS_FINE)) begin
                rv = {26'h0, st_reg.fine[ch]};
            end else if (s_axi_araddr == OFS_RANGE) begin
                rv = {24'h0, st_reg.rng};
            end else if (s_axi_araddr == OFS_FUNC) begin
                rv = {26'h0, fv};
            end else if (s_axi_araddr == OFS_STATUS) begin
                rv[S_CLAMP] = st_reg.clamp_gate;
                rv[S_SUPOK] = sup_ok;
                rv[S_SUPERVISOR_RESET_INPUT] = rin_ok;
            end else begin
                hit = 1'b0;
            end
            st_next.rdata  = rv;
            st_next.rresp  = hit ? RESP_OKAY : RESP_SLVERR;
            st_next.rvalid = 1'b1;
        end
        st_next.arready = !st_next.rvalid;

        // ****************************************
        // output clamp sequence
        // ****************************************
        case (st_reg.clamp)
            CL_CLAMPED: begin
                // stay clamped until supply and reset input good
                if (sup_ok && rin_ok) begin
                    st_next.clamp = CL_ARMED;
                end
            end
            CL_ARMED: begin
                if (!sup_ok || !rin_ok) begin
                    st_next.clamp = CL_CLAMPED;
                end else if (data_wr) begin
                    st_next.clamp = CL_RUN;
                end
            end
            CL_RUN: begin
                // supply loss or reset input re-clamps
                if (!sup_ok || !rin_ok) begin
                    st_next.clamp = CL_CLAMPED;
                end
            end
            default: begin
                st_next.clamp = CL_CLAMPED;
            end
        endcase
        st_next.amp_gate   = (st_next.clamp == CL_RUN);
        st_next.clamp_gate = (st_next.clamp != CL_RUN);
        st_next.det_n = sup_ok;

        // two's complement flips msb into binary core code
        for (int c = 0; c < NCH; c++) begin
            st_next.code[c] = st_next.func[F_BIN] ? st_next.data[c] : (st_next.data[c] ^ MSB_FLIP);
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            st_reg            <= '0;
            st_reg.data       <= {NCH{DATA_RST}};
            st_reg.code       <= {NCH{DATA_RST ^ MSB_FLIP}};
            st_reg.ofs        <= {NCH{OFFSET_RST}};
            st_reg.fine       <= {NCH{FINE_RST}};
            st_reg.rng        <= {NCH{RANGE_STD}};
            st_reg.func       <= FUNC_RST;
            st_reg.clamp      <= CL_CLAMPED;
            st_reg.clamp_gate <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign s_axi_awready            = st_reg.awready;
    assign s_axi_wready             = st_reg.wready;
    assign s_axi_bresp              = st_reg.bresp;
    assign s_axi_bvalid             = st_reg.bvalid;
    assign s_axi_arready            = st_reg.arready;
    assign s_axi_rdata              = st_reg.rdata;
    assign s_axi_rresp              = st_reg.rresp;
    assign s_axi_rvalid             = st_reg.rvalid;
    assign supply_detector_output_n = st_reg.det_n;
    assign amplifier_connect_gate   = st_reg.amp_gate;
    assign output_clamp_gate        = st_reg.clamp_gate;
    assign gp_port_pin_zero_o       = st_reg.func[F_D0VAL];
    assign gp_port_pin_zero_oe      = st_reg.func[F_D0DIR];
    assign gp_port_pin_one_o        = st_reg.func[F_D1VAL];
    assign gp_port_pin_one_oe       = st_reg.func[F_D1DIR];
    assign dac_code                 = st_reg.code;
    assign offset_trim_code         = st_reg.ofs;
    assign fine_trim_code           = st_reg.fine;
    assign range_code               = st_reg.rng;
    assign local_ground_adjust_en   = st_reg.func[F_LGND];

endmodule : dtc_trim_ctrl
`default_nettype wire

/* dtc_trim_ctrl_props.sv */
`timescale 1ns/100ps
`default_nettype none
module dtc_trim_ctrl_props
    import dtc_pkg::*;
(
    input wire logic          clk,                      // clock
    input wire logic          rst,                      // reset
    input wire logic          s_axi_awvalid,            // aw valid
    input wire logic          s_axi_awready,            // aw ready
    input wire logic          s_axi_wvalid,             // w valid
    input wire logic          s_axi_wready,             // w ready
    input wire logic          s_axi_bvalid,             // b valid
    input wire logic          s_axi_bready,             // b ready
    input wire logic [1:0]    s_axi_bresp,              // b resp
    input wire logic [AW-1:0] s_axi_araddr,             // ar addr
    input wire logic          s_axi_arvalid,            // ar valid
    input wire logic          s_axi_arready,            // ar ready
    input wire logic          s_axi_rvalid,             // r valid
    input wire logic [31:0]   s_axi_rdata,              // r data
    input wire logic [1:0]    s_axi_rresp,              // r resp
    input wire logic          supply_stable,            // supply pin
    input wire logic          supervisor_reset_input_n, // supervisor pin
    input wire logic          supply_detector_output_n, // detector out
    input wire logic          amplifier_connect_gate,   // amp gate
    input wire logic          output_clamp_gate         // clamp gate
);
    // ****************************************
    // output control and bus checks
    // ****************************************
    default clocking dcb @(posedge clk); endclocking
    default disable iff (rst);
    clamp_inverse_a: assert property (output_clamp_gate != amplifier_connect_gate)
        else $error("clamp and amplifier gates agree");
    supervisor_force_a: assert property (!supervisor_reset_input_n [*3] |=> output_clamp_gate)
        else $error("clamp not forced by supervisor");
    supply_loss_a: assert property (!supply_stable [*3] |=> output_clamp_gate)
        else $error("clamp not forced by supply loss");
    detector_high_a: assert property (supply_stable [*3] |=> supply_detector_output_n)
        else $error("detector low with good supply");
    detector_low_a: assert property (!supply_stable [*3] |=> !supply_detector_output_n)
        else $error("detector high with bad supply");
    clamp_release_a: assert property ($fell(output_clamp_gate) |-> $rose(s_axi_bvalid))
        else $error("clamp released without data write");
    write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> s_axi_bvalid && !s_axi_awready) else $error("write answer late");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
    resp_once_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    unmapped_read_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > OFS_STATUS
        |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read answered");
    cover property ($fell(output_clamp_gate));
    cover property (!supervisor_reset_input_n [*3] ##1 output_clamp_gate);
    cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule : dtc_trim_ctrl_props
bind dtc_trim_ctrl dtc_trim_ctrl_props u_props (
    .clk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .s_axi_rdata, .s_axi_rresp, .supply_stable, .supervisor_reset_input_n,
    .supply_detector_output_n, .amplifier_connect_gate, .output_clamp_gate
);
`default_nettype wire
